//--- rtl/rio_pkg.sv
// Constants and types for the RAM, I/O and timer array.
// Assumes one system clock that also times every processor bus cycle.

package rio_pkg;

    // ********************************************************
    // Clock, address and field layout
    // ********************************************************
    localparam int         CLK_PERIOD_NS    = 100;
    localparam int         RST_HOLD_NS      = 100;
    localparam int         RST_HOLD_CYCLES  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         RAM_DEPTH        = 128;
    localparam int         ADDR_W           = 7;
    localparam int         DATA_W           = 8;
    localparam int         SEL_BIT_SECTION  = 2;
    localparam int         SEL_BIT_TIMER    = 4;
    localparam int         SEL_BIT_IRQ_EN   = 3;
    localparam int         SEL_BIT_FLAGS    = 0;
    localparam int         EDGE_BIT_ENABLE  = 1;
    localparam int         EDGE_BIT_RISING  = 0;
    localparam int         FLAG_BIT_TIMER   = 7;
    localparam int         FLAG_BIT_EDGE    = 6;
    localparam int         PORT_TOP_LINE    = 7;
    localparam logic [1:0] PORT_IDX_A_OUT   = 2'h0;
    localparam logic [1:0] PORT_IDX_A_DIR   = 2'h1;
    localparam logic [1:0] PORT_IDX_B_OUT   = 2'h2;
    localparam logic [1:0] PORT_IDX_B_DIR   = 2'h3;
    localparam logic [7:0] PORT_RESET_VALUE = 8'h00;
    localparam logic [7:0] TIMER_AFTER_ZERO = 8'hff;

    // ********************************************************
    // Prescaler reloads for divide by 1, 8, 64 and 1024
    // ********************************************************
    localparam logic [9:0] TMR_RELOAD_DIV1    = 10'h000;
    localparam logic [9:0] TMR_RELOAD_DIV8    = 10'h007;
    localparam logic [9:0] TMR_RELOAD_DIV64   = 10'h03f;
    localparam logic [9:0] TMR_RELOAD_DIV1024 = 10'h3ff;

    // ********************************************************
    // Types
    // ********************************************************
    typedef struct packed {
        logic              cs_high;
        logic              cs_low_n;
        logic              ram_sel_n;
        logic              rd_wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } rio_req_t;

    typedef enum logic [3:0] {
        SEL_NONE     = 4'h0,
        SEL_RAM      = 4'h1,
        SEL_A_OUT    = 4'h3,
        SEL_A_DIR    = 4'h2,
        SEL_B_OUT    = 4'h6,
        SEL_B_DIR    = 4'h7,
        SEL_TMR_WR   = 4'h5,
        SEL_TMR_RD   = 4'h4,
        SEL_FLAGS_RD = 4'hc,
        SEL_EDGE_CTL = 4'hd
    } rio_sel_t;

endpackage : rio_pkg

//--- rtl/rio_ram_io_port_array.sv
// RAM, two bidirectional ports and an interval timer behind a processor bus.
// Assumes the processor drives its bus pins from logic on CLK_IN; port pins
// come from outside and are synchronised here.

module rio_ram_io_port_array
    import rio_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    input  wire logic        CHIP_SELECT_HIGH_IN,
    input  wire logic        CHIP_SELECT_LOW_N_IN,
    input  wire logic        RAM_SELECT_N_IN,
    input  wire logic        READ_WRITE_IN,
    input  wire logic [6:0]  ADDRESS_LINES_IN,
    input  wire logic [7:0]  DATA_BUS_LINES_IN,
    output logic      [7:0]  DATA_BUS_LINES_OUT,
    output logic             DATA_BUS_LINES_OE_OUT,
    input  wire logic [7:0]  PORT_A_LINES_IN,
    output logic      [7:0]  PORT_A_LINES_OUT,
    output logic      [7:0]  PORT_A_LINES_OE_OUT,
    input  wire logic [7:0]  PORT_B_LINES_IN,
    output logic      [7:0]  PORT_B_LINES_OUT,
    output logic      [7:0]  PORT_B_LINES_OE_OUT,
    output logic             IRQ_N_OUT,
    output logic             IRQ_N_OE_OUT
);

    // ********************************************************
    // Address decode
    // ********************************************************
    function automatic rio_sel_t decode(input rio_req_t r);
        rio_sel_t s;
        s = SEL_NONE;
        if (r.cs_high && !r.cs_low_n)
        begin
            if (!r.ram_sel_n)
                s = SEL_RAM;
            else if (!r.addr[SEL_BIT_SECTION])
            begin
                unique case (r.addr[1:0])
                    PORT_IDX_A_OUT: s = SEL_A_OUT;
                    PORT_IDX_A_DIR: s = SEL_A_DIR;
                    PORT_IDX_B_OUT: s = SEL_B_OUT;
                    PORT_IDX_B_DIR: s = SEL_B_DIR;
                endcase
            end
            else if (!r.rd_wr)
                s = r.addr[SEL_BIT_TIMER] ? SEL_TMR_WR : SEL_EDGE_CTL;
            else
                s = r.addr[SEL_BIT_FLAGS] ? SEL_FLAGS_RD : SEL_TMR_RD;
        end
        return s;
    endfunction : decode

    function automatic logic [9:0] reload_of(input logic [1:0] code);
        logic [9:0] v;
        unique case (code)
            2'h0: v = TMR_RELOAD_DIV1;
            2'h1: v = TMR_RELOAD_DIV8;
            2'h2: v = TMR_RELOAD_DIV64;
            2'h3: v = TMR_RELOAD_DIV1024;
        endcase
        return v;
    endfunction : reload_of

    rio_req_t         req;
    rio_sel_t         sel;
    logic             wr_hit;
    logic             rd_hit;

    // Bus pins come from processor logic on the same clock: no synchroniser
    assign req    = '{CHIP_SELECT_HIGH_IN, CHIP_SELECT_LOW_N_IN, RAM_SELECT_N_IN,
                      READ_WRITE_IN, ADDRESS_LINES_IN, DATA_BUS_LINES_IN};
    assign sel    = decode(req);
    assign wr_hit = (sel != SEL_NONE) && !req.rd_wr;
    assign rd_hit = (sel != SEL_NONE) && req.rd_wr;

    // ********************************************************
    // Port pin synchronisers
    // ********************************************************
    logic [15:0] pin_raw;
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [15:0] pin_s3;
    logic [15:0] pin_level;

    assign pin_raw = {PORT_B_LINES_IN, PORT_A_LINES_IN};

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_pin_sync
            // Change is taken only once two stages agree, filtering glitches
            // Runs through reset, so release shows the true idle level
            always_ff @(posedge CLK_IN)
            begin
                pin_s1[gi] <= pin_raw[gi];
                pin_s2[gi] <= pin_s1[gi];
                pin_s3[gi] <= pin_s2[gi];
                if (pin_s2[gi] == pin_s3[gi])
                    pin_level[gi] <= pin_s3[gi];
            end
        end
    endgenerate

    logic [7:0] pa_pin;
    logic [7:0] pb_pin;
    assign pa_pin = pin_level[7:0];
    assign pb_pin = pin_level[15:8];

    // ********************************************************
    // Port registers
    // ********************************************************
    logic [7:0] port_a_output;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_output;
    logic [7:0] port_b_direction;

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            port_a_output    <= PORT_RESET_VALUE;
            port_a_direction <= PORT_RESET_VALUE;
            port_b_output    <= PORT_RESET_VALUE;
            port_b_direction <= PORT_RESET_VALUE;
        end
        else if (wr_hit)
        begin
            if (sel == SEL_A_OUT)
                port_a_output <= req.data;
            if (sel == SEL_A_DIR)
                port_a_direction <= req.data;
            if (sel == SEL_B_OUT)
                port_b_output <= req.data;
            if (sel == SEL_B_DIR)
                port_b_direction <= req.data;
        end
    end

    // Pins mirror the registers; enable high drives the line
    assign PORT_A_LINES_OUT    = port_a_output;
    assign PORT_A_LINES_OE_OUT = port_a_direction;
    assign PORT_B_LINES_OUT    = port_b_output;
    assign PORT_B_LINES_OE_OUT = port_b_direction;

    // ********************************************************
    // RAM
    // ********************************************************
    logic [7:0] ram [RAM_DEPTH];

    // No reset on the array: contents are undefined until written
    always_ff @(posedge CLK_IN)
    begin
        if (wr_hit && sel == SEL_RAM)
            ram[req.addr] <= req.data;
    end

    // ********************************************************
    // Interval timer
    // ********************************************************
    logic [7:0] timer_count;
    logic [9:0] prescale;
    logic [9:0] reload;
    logic       timer_irq_en;
    logic       timer_flag;
    logic       expire;

    assign expire = !timer_flag && prescale == 10'h000 && timer_count == 8'h00
                    && sel != SEL_TMR_WR;

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            timer_count <= 8'h00;
            prescale    <= 10'h000;
            reload      <= TMR_RELOAD_DIV1;
        end
        else if (sel == SEL_TMR_WR)
        begin
            // Prescaler starts empty so the first step comes one clock later
            timer_count <= req.data;
            reload      <= reload_of(req.addr[1:0]);
            prescale    <= 10'h000;
        end
        else if (timer_flag)
            timer_count <= timer_count - 8'h01;
        else if (prescale == 10'h000)
        begin
            prescale    <= reload;
            timer_count <= (timer_count == 8'h00) ? TIMER_AFTER_ZERO
                                                  : timer_count - 8'h01;
        end
        else
            prescale <= prescale - 10'h001;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            timer_irq_en <= 1'b0;
        else if (sel == SEL_TMR_WR || sel == SEL_TMR_RD)
            timer_irq_en <= req.addr[SEL_BIT_IRQ_EN];
    end

    // Expiry in the clearing read keeps the flag set; a timer write blocks expiry
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            timer_flag <= 1'b0;
        else if (expire)
            timer_flag <= 1'b1;
        else if (sel == SEL_TMR_WR || sel == SEL_TMR_RD)
            timer_flag <= 1'b0;
    end

    // ********************************************************
    // Top port A line edge sense
    // ********************************************************
    logic edge_irq_en;
    logic edge_rising;
    logic edge_flag;
    logic top_prev;
    logic edge_seen;

    assign edge_seen = edge_rising ? (pa_pin[PORT_TOP_LINE] && !top_prev)
                                   : (!pa_pin[PORT_TOP_LINE] && top_prev);

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            edge_irq_en <= 1'b0;
            edge_rising <= 1'b0;
        end
        else if (sel == SEL_EDGE_CTL)
        begin
            edge_irq_en <= req.addr[EDGE_BIT_ENABLE];
            edge_rising <= req.addr[EDGE_BIT_RISING];
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            edge_flag <= 1'b0;
        else if (edge_seen)
            edge_flag <= 1'b1;
        else if (sel == SEL_FLAGS_RD)
            edge_flag <= 1'b0;
    end

    // Follows the pin through reset: no false edge at release
    always_ff @(posedge CLK_IN)
    begin
        top_prev <= pa_pin[PORT_TOP_LINE];
    end

    // ********************************************************
    // Interrupt request, open drain
    // ********************************************************
    logic irq_drive;
    logic irq_level;

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            irq_drive <= 1'b0;
            irq_level <= 1'b0;
        end
        else
        begin
            // Pin only ever pulled low; the wire idles high by its pull-up
            irq_drive <= (timer_flag && timer_irq_en)
                         || (edge_flag && edge_irq_en);
            irq_level <= 1'b0;
        end
    end

    assign IRQ_N_OUT    = irq_level;
    assign IRQ_N_OE_OUT = irq_drive;

    // ********************************************************
    // Read data path
    // ********************************************************
    logic [7:0] next_read;
    logic [7:0] read_data;
    logic       read_oe;

    always_comb
    begin
        next_read = 8'h00;
        unique case (sel)
            SEL_RAM:      next_read = ram[req.addr];
            SEL_A_OUT:    next_read = pa_pin;
            SEL_A_DIR:    next_read = port_a_direction;
            SEL_B_OUT:    next_read = (port_b_direction & port_b_output)
                                      | (~port_b_direction & pb_pin);
            SEL_B_DIR:    next_read = port_b_direction;
            SEL_TMR_RD:   next_read = timer_count;
            SEL_FLAGS_RD: next_read = {timer_flag, edge_flag, 6'h00};
            SEL_NONE,
            SEL_TMR_WR,
            SEL_EDGE_CTL: next_read = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            read_data <= 8'h00;
            read_oe   <= 1'b0;
        end
        else
        begin
            read_data <= next_read;
            read_oe   <= rd_hit;
        end
    end

    assign DATA_BUS_LINES_OUT    = read_data;
    assign DATA_BUS_LINES_OE_OUT = read_oe;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);

    a_reset_clears_ports: assert property ($past(SRST_IN) |->
        port_a_direction == 8'h00 && port_b_direction == 8'h00
        && port_a_output == 8'h00 && port_b_output == 8'h00)
        else $error("port registers not zero after reset");

    a_reset_quiet_bus: assert property ($past(SRST_IN) |->
        !DATA_BUS_LINES_OE_OUT && !IRQ_N_OE_OUT && !timer_irq_en && !edge_irq_en)
        else $error("bus or interrupt active after reset");

    a_read_drives_bus: assert property (rd_hit |=> DATA_BUS_LINES_OE_OUT)
        else $error("selected read not driven");

    a_idle_bus_off: assert property (!rd_hit |=> !DATA_BUS_LINES_OE_OUT)
        else $error("data bus driven outside a selected read");

    a_dir_write_drive: assert property ((wr_hit && sel == SEL_A_DIR)
        |=> PORT_A_LINES_OE_OUT == $past(req.data))
        else $error("direction write not reflected on enables");

    a_out_write_drive: assert property ((wr_hit && sel == SEL_B_OUT)
        |=> PORT_B_LINES_OUT == $past(req.data))
        else $error("output write not reflected on pins");

    a_port_a_read: assert property ((rd_hit && sel == SEL_A_OUT)
        |=> DATA_BUS_LINES_OUT == $past(pa_pin))
        else $error("port A read not from pins");

    a_port_b_read: assert property ((rd_hit && sel == SEL_B_OUT)
        |=> DATA_BUS_LINES_OUT == (($past(port_b_direction) & $past(port_b_output))
            | (~$past(port_b_direction) & $past(pb_pin))))
        else $error("port B read mixes wrong sources");

    a_ram_roundtrip: assert property ((wr_hit && sel == SEL_RAM)
        ##2 (rd_hit && sel == SEL_RAM && req.addr == $past(req.addr, 2))
        |=> DATA_BUS_LINES_OUT == $past(req.data, 3))
        else $error("RAM read back differs from write");

    a_irq_cause: assert property ($rose(IRQ_N_OE_OUT) |->
        $past((timer_flag && timer_irq_en) || (edge_flag && edge_irq_en)))
        else $error("interrupt without enabled source");

    a_irq_open_drain: assert property (IRQ_N_OE_OUT |-> !IRQ_N_OUT)
        else $error("interrupt pin driven high");

    a_irq_follows: assert property (IRQ_N_OE_OUT ==
        $past((timer_flag && timer_irq_en) || (edge_flag && edge_irq_en)))
        else $error("interrupt request not following enabled flags");

    a_timer_one_tick: assert property ((sel == SEL_TMR_WR && req.data == 8'h00
        && req.addr[1:0] == 2'h0) |=> ##1 timer_flag)
        else $error("shortest interval not one period");

    c_timer_expiry:  cover property (expire && timer_irq_en);
    c_edge_flag:     cover property (edge_seen && edge_irq_en);
    c_ram_roundtrip: cover property ((wr_hit && sel == SEL_RAM) ##2 (rd_hit && sel == SEL_RAM));
    c_port_b_read:   cover property (rd_hit && sel == SEL_B_OUT && port_b_direction != 8'h00);

endmodule : rio_ram_io_port_array

//--- test/rio_cpu_model.sv
// Processor model that runs bus cycles on the system data bus of the port array.
// Assumes the bench supplies the clock and calls cycle just after a rising edge.
module rio_cpu_model
    import rio_pkg::*;
(
    input  wire logic       clk_in,
    output logic            cs_high_out,
    output logic            cs_low_n_out,
    output logic            ram_sel_n_out,
    output logic            rd_wr_out,
    output logic [6:0]      addr_out,
    output logic [7:0]      data_out,
    input  wire logic [7:0] dev_data_in,
    input  wire logic       dev_oe_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       drive;
    logic [7:0] wdata;
    logic [7:0] last;
    // ********************************************************
    // Bus wire
    // ********************************************************
    // Released bus toggles, so a stale byte never reads as valid
    assign data_out = dev_oe_in ? dev_data_in : (drive ? wdata : ~last);
    always_ff @(posedge clk_in) last <= data_out;
    initial
    begin
        cs_high_out   = 1'b0;
        cs_low_n_out  = 1'b1;
        ram_sel_n_out = 1'b0;
        rd_wr_out     = 1'b1;
        addr_out      = 7'h00;
        drive         = 1'b0;
        wdata         = 8'h00;
    end
    // ********************************************************
    // One bus cycle, held until the taking edge
    // ********************************************************
    task automatic cycle(input logic sel, input logic rs_n, input logic rw,
                         input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] q, output logic oe);
        @(posedge clk_in);
        cs_high_out   <= sel;
        cs_low_n_out  <= ~sel;
        ram_sel_n_out <= rs_n;
        rd_wr_out     <= rw;
        addr_out      <= a;
        wdata         <= d;
        drive         <= ~rw;
        @(posedge clk_in);
        cs_high_out   <= 1'b0;
        cs_low_n_out  <= 1'b1;
        drive         <= 1'b0;
        #1;
        q  = dev_data_in;
        oe = dev_oe_in;
    endtask : cycle
endmodule : rio_cpu_model

//--- test/rio_ram_io_port_array_test.sv
// Self-checking bench for the RAM, I/O and timer array.
// Assumes the processor model drives the bus and the bench drives port pins.
module rio_ram_io_port_array_test
    import rio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, srst, cs_h, cs_l_n, rs_n, rw, doe, irq_n, irq_oe;
    logic [6:0] addr;
    logic [7:0] dbus, dout, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
    logic [7:0] ext_a, ext_b, load_a, load_b, q;
    logic       oe;
    int         err_count, comparisons, cycles;
    // Loads pull driven lines low, as a heavy peripheral would
    assign pa_in = (pa_oe & pa_out & ~load_a) | (~pa_oe & ext_a);
    assign pb_in = (pb_oe & pb_out & ~load_b) | (~pb_oe & ext_b);
    rio_ram_io_port_array uut (.CLK_IN(clk), .SRST_IN(srst), .CHIP_SELECT_HIGH_IN(cs_h),
        .CHIP_SELECT_LOW_N_IN(cs_l_n), .RAM_SELECT_N_IN(rs_n), .READ_WRITE_IN(rw),
        .ADDRESS_LINES_IN(addr), .DATA_BUS_LINES_IN(dbus), .DATA_BUS_LINES_OUT(dout),
        .DATA_BUS_LINES_OE_OUT(doe), .PORT_A_LINES_IN(pa_in), .PORT_A_LINES_OUT(pa_out),
        .PORT_A_LINES_OE_OUT(pa_oe), .PORT_B_LINES_IN(pb_in), .PORT_B_LINES_OUT(pb_out),
        .PORT_B_LINES_OE_OUT(pb_oe), .IRQ_N_OUT(irq_n), .IRQ_N_OE_OUT(irq_oe));
    rio_cpu_model cpu (.clk_in(clk), .cs_high_out(cs_h), .cs_low_n_out(cs_l_n),
        .ram_sel_n_out(rs_n), .rd_wr_out(rw), .addr_out(addr), .data_out(dbus),
        .dev_data_in(dout), .dev_oe_in(doe));
    // ********************************************************
    // Clock, timeout and report
    // ********************************************************
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            $display("BAD timeout");
            results();
        end
    end
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // ********************************************************
    // Bus helpers
    // ********************************************************
    task automatic wr(input logic s, input logic [6:0] a, input logic [7:0] d);
        cpu.cycle(1'b1, s, 1'b0, a, d, q, oe);
    endtask : wr
    task automatic rd(input logic s, input logic [6:0] a, input logic [7:0] e, input string n);
        cpu.cycle(1'b1, s, 1'b1, a, 8'h00, q, oe);
        chk({n, "_oe"}, 8'h01, {7'h00, oe});
        chk(n, e, q);
    endtask : rd
    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_reset(input string n);
        @(posedge clk);
        srst <= 1'b1;
        cpu.cycle(1'b1, 1'b0, 1'b1, 7'h00, 8'h00, q, oe);  // Read during reset
        chk({n, "_bus_oe"}, 8'h00, {7'h00, oe});
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk({n, "_oe_a"}, 8'h00, pa_oe);
        chk({n, "_oe_b"}, 8'h00, pb_oe);
        chk({n, "_irq"}, 8'h00, {7'h00, irq_oe});
        chk({n, "_out_a"}, 8'h00, pa_out);
        chk({n, "_out_b"}, 8'h00, pb_out);
        rd(1'b1, 7'h01, 8'h00, {n, "_dir_a"});
        rd(1'b1, 7'h03, 8'h00, {n, "_dir_b"});
    endtask : t_reset
    task automatic t_ram();
        wr(1'b0, 7'h00, 8'ha5);
        wr(1'b0, 7'h7f, 8'h5a);
        rd(1'b0, 7'h7f, 8'h5a, "ram_rt");
        wr(1'b1, 7'h00, 8'h11);                        // Port section, RAM untouched
        cpu.cycle(1'b0, 1'b0, 1'b0, 7'h00, 8'hff, q, oe);  // Deselected write
        cpu.cycle(1'b0, 1'b0, 1'b1, 7'h00, 8'h00, q, oe);  // Deselected read
        chk("desel_oe", 8'h00, {7'h00, oe});
        rd(1'b0, 7'h00, 8'ha5, "ram_lo");
        rd(1'b0, 7'h7f, 8'h5a, "ram_hi");
    endtask : t_ram
    task automatic t_ports();
        @(posedge clk);
        ext_a <= 8'h0f;
        ext_b <= 8'hf0;
        wr(1'b1, 7'h01, 8'ha5);
        wr(1'b1, 7'h00, 8'h3c);
        wr(1'b1, 7'h03, 8'h5a);
        wr(1'b1, 7'h02, 8'hc3);
        chk("oe_a", 8'ha5, pa_oe);
        chk("pins_a", 8'h3c, pa_out);
        chk("oe_b", 8'h5a, pb_oe);
        chk("pins_b", 8'hc3, pb_out);
        rd(1'b1, 7'h01, 8'ha5, "dir_a");
        rd(1'b1, 7'h03, 8'h5a, "dir_b");
        rd(1'b1, 7'h00, (8'h3c & 8'ha5) | (8'h0f & ~8'ha5), "rd_a");
        rd(1'b1, 7'h02, (8'hc3 & 8'h5a) | (8'hf0 & ~8'h5a), "rd_b");
        @(posedge clk);
        load_a <= 8'hff;
        load_b <= 8'hff;
        repeat (6) @(posedge clk);                     // Pin sync latency
        rd(1'b1, 7'h00, 8'h0f & ~8'ha5, "load_a");
        rd(1'b1, 7'h02, (8'hc3 & 8'h5a) | (8'hf0 & ~8'h5a), "load_b");
        @(posedge clk);
        load_a <= 8'h00;
        load_b <= 8'h00;
    endtask : t_ports
    task automatic t_timer();
        wr(1'b1, 7'h1d, 8'h02);                        // Count 2, divide 8, request on
        repeat (2 * 8 + 1) @(posedge clk);
        #1;
        chk("irq_early", 8'h00, {7'h00, irq_oe});
        @(posedge clk);
        #1;
        chk("irq_on", 8'h01, {7'h00, irq_oe});
        chk("irq_lvl", 8'h00, {7'h00, irq_n});
        rd(1'b1, 7'h04, 8'hfd, "tmr_cnt");
        repeat (2) @(posedge clk);
        #1;
        chk("irq_off", 8'h00, {7'h00, irq_oe});
        wr(1'b1, 7'h1c, 8'h01);
        repeat (4) @(posedge clk);
        #1;
        chk("irq_again", 8'h01, {7'h00, irq_oe});
        wr(1'b1, 7'h1c, 8'h00);                        // Zero count, divide 1
        rd(1'b1, 7'h05, 8'h80, "tmr_flag");
    endtask : t_timer
    task automatic t_edge();
        cpu.cycle(1'b1, 1'b1, 1'b1, 7'h04, 8'h00, q, oe);  // Clear timer flag
        wr(1'b1, 7'h07, 8'h00);                        // Rising edge, request on
        @(posedge clk);
        ext_a <= 8'h8f;
        repeat (5) @(posedge clk);
        #1;
        chk("edge_early", 8'h00, {7'h00, irq_oe});
        @(posedge clk);
        #1;
        chk("edge_irq", 8'h01, {7'h00, irq_oe});
        rd(1'b1, 7'h05, 8'h40, "flags");
        @(posedge clk);
        #1;
        chk("edge_off", 8'h00, {7'h00, irq_oe});
    endtask : t_edge
    initial
    begin
        clk         = 1'b0;
        srst        = 1'b1;
        ext_a       = 8'h00;
        ext_b       = 8'h00;
        load_a      = 8'h00;
        load_b      = 8'h00;
        err_count   = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_ram();
        t_reset("first");
        t_ports();
        t_timer();
        t_reset("mid");
        t_edge();
        results();
    end
endmodule : rio_ram_io_port_array_test
